// >>> logic/pcsr_defs.svh
// Purpose: offsets, field positions, reset values and counts of the
//          coding-sublayer control and status registers
// Assumes: included by its bare name
// Notes:   register offsets are indices; byte address is four times
//          the index once the bank nibble is dropped
`ifndef PCSR_DEFS_SVH
`define PCSR_DEFS_SVH

// ---------------------------------------------------------------
// register offsets as printed
// ---------------------------------------------------------------
`define PCSR_OFS_CTRL 16'h3000
`define PCSR_OFS_CTRL_ALT 16'h38E6
`define PCSR_OFS_STATUS 16'h38E7
`define PCSR_BANK_MASK 16'h0FFF

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PCSR_CTRL_RST_BIT 15
`define PCSR_CTRL_LPBK_BIT 14
`define PCSR_ST_TXLPI_LAT_BIT 11
`define PCSR_ST_RXLPI_LAT_BIT 10
`define PCSR_ST_TXLPI_NOW_BIT 9
`define PCSR_ST_RXLPI_NOW_BIT 8
`define PCSR_ST_FAULT_BIT 7
`define PCSR_ST_LINK_BIT 2

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define PCSR_CTRL_RESET 16'h0000
`define PCSR_STATUS_RESET 16'h0000
`define PCSR_CTRL_USED_MASK 16'hC000
`define PCSR_ST_USED_MASK 16'h0F84
`define PCSR_RESET_CYCLES 16

`endif

// >>> logic/pcsr_pkg.sv
// Purpose: types shared by the coding-sublayer register bank
// Assumes: nothing
// Notes:   constants live in pcsr_defs.svh
package pcsr_pkg;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    PCSR_BUS_IDLE = 1'b0,
    PCSR_BUS_ANSWER = 1'b1
  } pcsr_bus_e;

  typedef enum logic [1:0] {
    PCSR_SEQ_IDLE = 2'b00,
    PCSR_SEQ_HOLD = 2'b01,
    PCSR_SEQ_DONE = 2'b10
  } pcsr_seq_e;

  // ---------------------------------------------------------------
  // state records
  // ---------------------------------------------------------------
  typedef struct packed {
    pcsr_seq_e state;
    logic [15:0] count;
    logic busy;
    logic sub_reset;
  } pcsr_seq_s;

  typedef struct packed {
    pcsr_bus_e bus;
    logic waitrequest;
    logic [31:0] readdata;
    logic loopback;
    logic tx_lpi_lat;
    logic rx_lpi_lat;
    logic tx_lpi_now;
    logic rx_lpi_now;
    logic fault_lat;
    logic link_stat;
  } pcsr_regs_s;

endpackage

// >>> logic/pcsr_reset_seq.sv
// Purpose: sequencer for the self-clearing coding-sublayer reset
// Assumes: start is a one-cycle pulse from the register bank
// Notes:   busy covers the whole sequence so the bit reads one until done
`timescale 1ns/10ps
`include "pcsr_defs.svh"
module pcsr_reset_seq #(
  parameter int RESET_CYCLES = `PCSR_RESET_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic start,
  // status and reset out
  output logic busy,
  output logic sub_reset
);

  pcsr_pkg::pcsr_seq_s r;
  pcsr_pkg::pcsr_seq_s next_r;

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    case (r.state)
      pcsr_pkg::PCSR_SEQ_IDLE: begin
        if (start) begin
          next_r.state = pcsr_pkg::PCSR_SEQ_HOLD;
          next_r.count = 16'h0000;
          next_r.busy = 1'b1;
          next_r.sub_reset = 1'b1;
        end
      end
      pcsr_pkg::PCSR_SEQ_HOLD: begin
        if (r.count == 16'(RESET_CYCLES - 1)) begin
          next_r.state = pcsr_pkg::PCSR_SEQ_DONE;
          next_r.sub_reset = 1'b0;
        end else begin
          next_r.count = r.count + 16'h0001;
        end
      end
      pcsr_pkg::PCSR_SEQ_DONE: begin
        // one quiet cycle so the sublayer leaves reset before bit clears
        next_r.state = pcsr_pkg::PCSR_SEQ_IDLE;
        next_r.busy = 1'b0;
      end
      default: begin
        next_r.state = pcsr_pkg::PCSR_SEQ_IDLE;
        next_r.busy = 1'b0;
        next_r.sub_reset = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{pcsr_pkg::PCSR_SEQ_IDLE, 16'h0000, 1'b0, 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign busy = r.busy;
  assign sub_reset = r.sub_reset;

endmodule

// >>> logic/pcsr_regs.sv
// Purpose: coding-sublayer control and status register bank on Avalon-MM
// Assumes: status inputs synchronous to clk; bank nibble already dropped
// Notes:   both control locations alias the same reset and loopback bits
//
// Summary of operation
// - Writing one to control bit 15 resets the coding sublayer; zero is normal.
// - The reset bit clears itself once the reset sequence has finished.
// - Control bit 14 enables loopback when one and disables it when zero.
// - Status bit 11 latches transmit low-power idle until a write of zero.
// - Status bit 10 latches receive low-power idle until a write of zero.
// - Status bit 9 shows transmit low-power idle being received now.
// - Status bit 8 shows receive low-power idle being received now.
// - Status bit 7 latches a fault until a write of zero clears it.
// - Status bit 2 reports receive link, and a write of zero sets it.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`include "pcsr_defs.svh"
module pcsr_regs #(
  parameter int RESET_CYCLES = `PCSR_RESET_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sublayer status in
  input wire logic tx_lpi_active,
  input wire logic rx_lpi_active,
  input wire logic fault_event,
  input wire logic rx_link_up,
  // sublayer control out
  output logic coding_layer_soft_reset,
  output logic coding_layer_loopback_en
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_CTRL = `PCSR_OFS_CTRL & `PCSR_BANK_MASK;
  localparam logic [15:0] OFS_ALT = `PCSR_OFS_CTRL_ALT & `PCSR_BANK_MASK;
  localparam logic [15:0] OFS_ST = `PCSR_OFS_STATUS & `PCSR_BANK_MASK;
  localparam logic [15:0] ST_USED = `PCSR_ST_USED_MASK;
  localparam logic [15:0] CTRL_USED = `PCSR_CTRL_USED_MASK;

  pcsr_pkg::pcsr_regs_s r;
  pcsr_pkg::pcsr_regs_s next_r;

  logic [11:0] index;
  logic hit_ctrl;
  logic hit_st;
  logic req;
  logic rd_load;
  logic wr_go;
  logic wr_ctrl_hi;
  logic wr_st_hi;
  logic wr_st_lo;
  logic start_reset;
  logic seq_busy;
  logic seq_reset;
  logic clr_tx;
  logic clr_rx;
  logic clr_fault;
  logic set_link;
  logic [15:0] ctrl_word;
  logic [15:0] st_word;

  // word index; the bank nibble never reaches the bus
  assign index = avs_address[13:2];
  assign hit_ctrl = (index == OFS_CTRL[11:0]) || (index == OFS_ALT[11:0]);
  assign hit_st = (index == OFS_ST[11:0]);
  assign req = avs_read || avs_write;

  // reads are captured one edge ahead so data stands at the taking edge
  assign rd_load = avs_read && (r.bus == pcsr_pkg::PCSR_BUS_IDLE);
  // writes take effect only at the edge where waitrequest is seen low
  assign wr_go = avs_write && (r.bus == pcsr_pkg::PCSR_BUS_ANSWER);
  assign wr_ctrl_hi = wr_go && hit_ctrl && avs_byteenable[1];
  assign wr_st_hi = wr_go && hit_st && avs_byteenable[1];
  assign wr_st_lo = wr_go && hit_st && avs_byteenable[0];

  // ---------------------------------------------------------------
  // software actions
  // ---------------------------------------------------------------
  assign start_reset = wr_ctrl_hi &&
    avs_writedata[`PCSR_CTRL_RST_BIT] && !seq_busy;
  assign clr_tx = wr_st_hi && !avs_writedata[`PCSR_ST_TXLPI_LAT_BIT];
  assign clr_rx = wr_st_hi && !avs_writedata[`PCSR_ST_RXLPI_LAT_BIT];
  assign clr_fault = wr_st_lo && !avs_writedata[`PCSR_ST_FAULT_BIT];
  assign set_link = wr_st_lo && !avs_writedata[`PCSR_ST_LINK_BIT];

  // ---------------------------------------------------------------
  // read words
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_word = `PCSR_CTRL_RESET;
    ctrl_word[`PCSR_CTRL_RST_BIT] = seq_busy;
    ctrl_word[`PCSR_CTRL_LPBK_BIT] = r.loopback;
    st_word = `PCSR_STATUS_RESET;
    st_word[`PCSR_ST_TXLPI_LAT_BIT] = r.tx_lpi_lat;
    st_word[`PCSR_ST_RXLPI_LAT_BIT] = r.rx_lpi_lat;
    st_word[`PCSR_ST_TXLPI_NOW_BIT] = r.tx_lpi_now;
    st_word[`PCSR_ST_RXLPI_NOW_BIT] = r.rx_lpi_now;
    st_word[`PCSR_ST_FAULT_BIT] = r.fault_lat;
    st_word[`PCSR_ST_LINK_BIT] = r.link_stat;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.tx_lpi_now = tx_lpi_active;
    next_r.rx_lpi_now = rx_lpi_active;
    // set wins over a clear in the same cycle
    next_r.tx_lpi_lat = tx_lpi_active || (r.tx_lpi_lat && !clr_tx);
    next_r.rx_lpi_lat = rx_lpi_active || (r.rx_lpi_lat && !clr_rx);
    next_r.fault_lat = fault_event || (r.fault_lat && !clr_fault);
    // link is latched low: a drop outranks a software set
    if (!rx_link_up) begin
      next_r.link_stat = 1'b0;
    end else if (set_link) begin
      next_r.link_stat = 1'b1;
    end
    if (wr_ctrl_hi) begin
      next_r.loopback = avs_writedata[`PCSR_CTRL_LPBK_BIT];
    end
    case (r.bus)
      pcsr_pkg::PCSR_BUS_IDLE: begin
        if (req) begin
          next_r.bus = pcsr_pkg::PCSR_BUS_ANSWER;
          next_r.waitrequest = 1'b0;
          if (rd_load && hit_ctrl) begin
            next_r.readdata = {16'h0000, ctrl_word};
          end else if (rd_load && hit_st) begin
            next_r.readdata = {16'h0000, st_word};
          end else begin
            // unmapped and write cycles return zero
            next_r.readdata = 32'h0000_0000;
          end
        end
      end
      pcsr_pkg::PCSR_BUS_ANSWER: begin
        next_r.bus = pcsr_pkg::PCSR_BUS_IDLE;
        next_r.waitrequest = 1'b1;
      end
      default: begin
        next_r.bus = pcsr_pkg::PCSR_BUS_IDLE;
        next_r.waitrequest = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{pcsr_pkg::PCSR_BUS_IDLE, 1'b1, 32'h0000_0000, 1'b0,
             1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  pcsr_reset_seq #(
    .RESET_CYCLES(RESET_CYCLES)
  ) u_seq (
    .clk(clk),
    .reset_n(reset_n),
    .start(start_reset),
    .busy(seq_busy),
    .sub_reset(seq_reset)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata = r.readdata;
  assign avs_waitrequest = r.waitrequest;
  assign coding_layer_loopback_en = r.loopback;
  assign coding_layer_soft_reset = seq_reset;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_RST_START: assert property (
    @(posedge clk) disable iff (!reset_n)
    start_reset |=> coding_layer_soft_reset && seq_busy
  ) else $error("soft reset did not start");

  AST_RST_ZERO: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_ctrl_hi && !avs_writedata[`PCSR_CTRL_RST_BIT] && !seq_busy)
    |=> !coding_layer_soft_reset
  ) else $error("write of zero started a reset");

  AST_RST_SELFCLR: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(seq_busy) |-> ##[1:40] !seq_busy
  ) else $error("reset bit did not clear itself");

  AST_RST_COVER: assert property (
    @(posedge clk) disable iff (!reset_n)
    coding_layer_soft_reset |-> seq_busy
  ) else $error("reset bit reads zero while reset held");

  AST_LOOPBACK: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_ctrl_hi |=>
    coding_layer_loopback_en == $past(avs_writedata[`PCSR_CTRL_LPBK_BIT])
  ) else $error("loopback does not follow write");

  AST_LOOP_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    !wr_ctrl_hi |=> $stable(coding_layer_loopback_en)
  ) else $error("loopback changed without a write");

  AST_TX_LAT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (tx_lpi_active || (r.tx_lpi_lat && !avs_write)) |=> r.tx_lpi_lat
  ) else $error("tx idle flag lost");

  AST_TX_CLR: assert property (
    @(posedge clk) disable iff (!reset_n)
    (clr_tx && !tx_lpi_active) |=> !r.tx_lpi_lat
  ) else $error("tx idle flag not cleared");

  AST_RX_LAT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rx_lpi_active || (r.rx_lpi_lat && !avs_write)) |=> r.rx_lpi_lat
  ) else $error("rx idle flag lost");

  AST_RX_CLR: assert property (
    @(posedge clk) disable iff (!reset_n)
    (clr_rx && !rx_lpi_active) |=> !r.rx_lpi_lat
  ) else $error("rx idle flag not cleared");

  AST_TX_NOW: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_load && hit_st) |-> ##1
    avs_readdata[`PCSR_ST_TXLPI_NOW_BIT] == $past(tx_lpi_active, 2)
  ) else $error("tx idle live bit wrong");

  AST_RX_NOW: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_load && hit_st) |-> ##1
    avs_readdata[`PCSR_ST_RXLPI_NOW_BIT] == $past(rx_lpi_active, 2)
  ) else $error("rx idle live bit wrong");

  AST_FAULT: assert property (
    @(posedge clk) disable iff (!reset_n)
    fault_event ##1 !clr_fault |=> r.fault_lat
  ) else $error("fault flag not held");

  AST_LINK_DOWN: assert property (
    @(posedge clk) disable iff (!reset_n)
    !rx_link_up |=> !r.link_stat
  ) else $error("link bit high after link drop");

  AST_LINK_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    (set_link && rx_link_up) |=> r.link_stat
  ) else $error("write of zero did not set link bit");

  AST_RSVD_ST: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_load && hit_st) |=>
    (avs_readdata[31:16] == 16'h0000) &&
    ((avs_readdata[15:0] & ~ST_USED) == 16'h0000)
  ) else $error("reserved status bits not zero");

  AST_RSVD_CTRL: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_load && hit_ctrl) |=>
    (avs_readdata[31:16] == 16'h0000) &&
    ((avs_readdata[15:0] & ~CTRL_USED) == 16'h0000)
  ) else $error("reserved control bits not zero");

  AST_ANSWER: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest
  ) else $error("bus answer not one cycle");

  AST_TX_SETWIN: assert property (
    @(posedge clk) disable iff (!reset_n)
    (clr_tx && tx_lpi_active) |=> r.tx_lpi_lat
  ) else $error("tx idle clear beat a set");

  AST_RX_SETWIN: assert property (
    @(posedge clk) disable iff (!reset_n)
    (clr_rx && rx_lpi_active) |=> r.rx_lpi_lat
  ) else $error("rx idle clear beat a set");

  AST_FAULT_CLR: assert property (
    @(posedge clk) disable iff (!reset_n)
    (clr_fault && !fault_event) |=> !r.fault_lat
  ) else $error("fault flag not cleared");

  AST_FAULT_SETWIN: assert property (
    @(posedge clk) disable iff (!reset_n)
    (clr_fault && fault_event) |=> r.fault_lat
  ) else $error("fault clear beat a set");

  AST_LINK_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rx_link_up && !set_link) |=> $stable(r.link_stat)
  ) else $error("link bit moved without cause");

  AST_RST_QUIET: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(coding_layer_soft_reset) |-> seq_busy ##1 !seq_busy
  ) else $error("reset bit did not clear after quiet cycle");

  AST_RST_IGNORED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (seq_busy && !coding_layer_soft_reset) |=> !coding_layer_soft_reset
  ) else $error("reset restarted while busy");

  AST_WR_AT_ANSWER: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_go |-> !avs_waitrequest
  ) else $error("write taken while waitrequest high");

  AST_RD_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    !avs_waitrequest |=> $stable(avs_readdata)
  ) else $error("read data moved after the taking edge");

  AST_CTRL_BUSY_BIT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_load && hit_ctrl) |=>
    avs_readdata[`PCSR_CTRL_RST_BIT] == $past(seq_busy)
  ) else $error("reset bit does not show the sequence");

  AST_UNMAPPED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_load && !hit_ctrl && !hit_st) |=> avs_readdata == 32'h0000_0000
  ) else $error("unmapped read not zero");

  AST_IDLE_WAIT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!req && avs_waitrequest) |=> avs_waitrequest
  ) else $error("waitrequest dropped with no request");

endmodule

// >>> testbench/pcsr_sw_master.sv
// Purpose: management software model driving the register bus
// Assumes: one request at a time; slave answers with waitrequest low
// Notes:   takes printed addresses and drops the bank nibble itself
`timescale 1ns/10ps
`include "pcsr_defs.svh"
module pcsr_sw_master (
  // clock
  input wire logic clk,
  // avalon-mm master side
  output logic [13:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 14'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
  end

  // -------------------------------------------------------------
  // one bus cycle
  // -------------------------------------------------------------
  // waits for the slave with no bound; the bench timeout cuts hangs
  task automatic access(input logic is_wr, input logic [15:0] printed,
                        input logic [15:0] wdata, input logic [3:0] be,
                        output logic [15:0] rdata);
    logic [15:0] idx;
    idx = printed & `PCSR_BANK_MASK;
    @(posedge clk);
    avs_address <= {idx[11:0], 2'b00};
    avs_read <= ~is_wr;
    avs_write <= is_wr;
    avs_writedata <= {16'h0000, wdata};
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // stale values left on the bus would hide a missing strobe check
    avs_address <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule

// >>> testbench/test_pcsr_regs.sv
// Purpose: self-checking bench for the coding-sublayer register bank
// Assumes: sublayer status inputs driven directly by the bench
// Notes:   short soft reset count keeps the run brief
`timescale 1ns/10ps
`include "pcsr_defs.svh"
module test_pcs_control_status_regs;
  localparam int RST_CYC = 4;
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [15:0] wd;
    logic [15:0] exp;
  } pcsr_row_s;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [13:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic tx_lpi_active, rx_lpi_active, fault_event, rx_link_up;
  logic coding_layer_soft_reset, coding_layer_loopback_en;
  int fail_count, n_checks, cyc, rst_hi;
  pcsr_row_s rows [11];

  always #5 clk = ~clk;

  pcsr_regs #(.RESET_CYCLES(RST_CYC)) u_dut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_lpi_active(tx_lpi_active), .rx_lpi_active(rx_lpi_active),
    .fault_event(fault_event), .rx_link_up(rx_link_up),
    .coding_layer_soft_reset(coding_layer_soft_reset),
    .coding_layer_loopback_en(coding_layer_loopback_en)
  );

  pcsr_sw_master u_sw (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  // -------------------------------------------------------------
  // reporting
  // -------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic [3:0] be);
    logic [15:0] x;
    u_sw.access(1'b1, a, d, be, x);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] x;
    u_sw.access(1'b0, a, 16'h0000, 4'hF, x);
    check16(x, exp);
  endtask

  // counts reset-high cycles and cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (coding_layer_soft_reset === 1'b1) rst_hi++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    tx_lpi_active = 1'b0;
    rx_lpi_active = 1'b0;
    fault_event = 1'b0;
    rx_link_up = 1'b0;
    rows = '{'{1'b0, 16'h3000, 16'h0000, 16'h0000},
             '{1'b0, 16'h38E6, 16'h0000, 16'h0000},
             '{1'b0, 16'h38E7, 16'h0000, 16'h0000},
             '{1'b1, 16'h3000, 16'h7FFF, 16'h0000},
             '{1'b0, 16'h3000, 16'h0000, 16'h4000},
             '{1'b0, 16'h38E6, 16'h0000, 16'h4000},
             '{1'b1, 16'h38E6, 16'h0000, 16'h0000},
             '{1'b0, 16'h3000, 16'h0000, 16'h0000},
             '{1'b1, 16'h3001, 16'hFFFF, 16'h0000},
             '{1'b1, 16'h38E7, 16'hFFFF, 16'h0000},
             '{1'b0, 16'h38E7, 16'h0000, 16'h0000}};
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wd, 4'hF);
      else rdchk(rows[i].addr, rows[i].exp);
    end
    rdchk(16'h3001, 16'h0000);
    $display("test table done");
    // self-clearing reset with loopback kept
    wr(`PCSR_OFS_CTRL, 16'h4000, 4'hF);
    // loopback lands at the taking edge; look once it has settled
    @(negedge clk);
    check1(coding_layer_loopback_en, 1'b1);
    rst_hi = 0;
    wr(`PCSR_OFS_CTRL_ALT, 16'hC000, 4'hF);
    // a second start while busy must be refused
    wr(`PCSR_OFS_CTRL, 16'hC000, 4'hF);
    rdchk(`PCSR_OFS_CTRL, 16'hC000);
    repeat (12) @(posedge clk);
    rdchk(`PCSR_OFS_CTRL_ALT, 16'h4000);
    // upper lane not enabled: neither reset nor loopback may move
    wr(`PCSR_OFS_CTRL, 16'h8000, 4'h1);
    rdchk(`PCSR_OFS_CTRL_ALT, 16'h4000);
    check16(16'(rst_hi), 16'(RST_CYC));
    $display("test soft reset done");
    // latched flags, cleared lane by lane
    @(posedge clk);
    tx_lpi_active <= 1'b1;
    fault_event <= 1'b1;
    @(posedge clk);
    tx_lpi_active <= 1'b0;
    fault_event <= 1'b0;
    rx_lpi_active <= 1'b1;
    @(posedge clk);
    rx_lpi_active <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(`PCSR_OFS_STATUS, 16'h0C80);
    wr(`PCSR_OFS_STATUS, 16'h0000, 4'h1);
    rdchk(`PCSR_OFS_STATUS, 16'h0C00);
    wr(`PCSR_OFS_STATUS, 16'h0400, 4'h3);
    rdchk(`PCSR_OFS_STATUS, 16'h0400);
    $display("test latched flags done");
    // live indications follow the inputs
    tx_lpi_active <= 1'b1;
    rx_lpi_active <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(`PCSR_OFS_STATUS, 16'h0F00);
    tx_lpi_active <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(`PCSR_OFS_STATUS, 16'h0D00);
    rx_lpi_active <= 1'b0;
    $display("test live bits done");
    // link status: write of zero sets it, link loss drops it
    rx_link_up <= 1'b1;
    wr(`PCSR_OFS_STATUS, 16'h0000, 4'hF);
    rdchk(`PCSR_OFS_STATUS, 16'h0004);
    rx_link_up <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(`PCSR_OFS_STATUS, 16'h0000);
    $display("test link done");
    // device reset in mid-run
    wr(`PCSR_OFS_CTRL, 16'h4000, 4'hF);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    check1(coding_layer_loopback_en, 1'b0);
    reset_n <= 1'b1;
    rdchk(`PCSR_OFS_CTRL, 16'h0000);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
